// *** verilog/mbpwm_pkg.sv ***
// package: constants and carrier types for the match based pwm unit
package mbpwm_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam int NUM_MATCH = 7;
    localparam int NUM_OUT = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] PRE_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // per match action field positions
    // ------------------------------------------------------------
    localparam int ACT_IRQ_BIT = 0;
    localparam int ACT_RESET_BIT = 1;
    localparam int ACT_STOP_BIT = 2;

    // counter run state, gray coded
    typedef enum logic [1:0] {
        MBPWM_HALT = 2'b00,
        MBPWM_RUN = 2'b01,
        MBPWM_STOPPED = 2'b11
    } mbpwm_state_type;

    // per match action: irq, reset, stop
    typedef struct packed {
        logic stop;
        logic reset;
        logic irq;
    } mbpwm_act_type;

    // per output configuration
    typedef struct packed {
        logic enable;
        logic double_edge;
    } mbpwm_outcfg_type;

endpackage : mbpwm_pkg

// *** verilog/mbpwm_unit.sv ***
// match based pwm unit: prescaled timer, seven match registers, six pwm outputs
//
// What this block does
// - counter counts prescaler ticks, acts on match equality
// - 32-bit counter behind programmable 32-bit prescaler
// - seven matches; in pwm mode match zero restarts the cycle
// - single edge output falls at its match
// - single edge outputs rise at match zero
// - each single edge output uses one match
// - double edge output uses two matches
// - each double edge output uses two matches
// - either edge order; positive or negative pulse
// - six single, three double, or mixed
// - match may continue, stop, reset, raise irq
// - period and widths any count, shared rate
// - in pwm mode while running, match updates take effect at cycle boundary
// - without pwm mode, plain timer behaviour
module mbpwm_unit (
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // control
    input wire logic count_enable_in,
    input wire logic counter_reset_in,
    input wire logic pwm_mode_in,
    input wire logic [31:0] prescale_limit_in,
    // match values, shadowed until released
    input wire logic [6:0][31:0] match_value_in,
    input wire logic [6:0] match_write_in,
    input wire logic [6:0] match_release_in,
    input wire mbpwm_pkg::mbpwm_act_type [6:0] match_action_in,
    // output configuration for outputs 1..6 (index 0 = output 1)
    input wire mbpwm_pkg::mbpwm_outcfg_type [5:0] out_cfg_in,
    // status
    output logic [31:0] count_out,
    output logic [31:0] prescale_count_out,
    output logic running_out,
    output logic [6:0] match_irq_out,
    output logic [6:0] match_hit_out,
    // pwm outputs
    output logic [5:0] pwm_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] pre_r, pre_nxt;
    mbpwm_pkg::mbpwm_state_type state_r, state_nxt;
    logic [6:0][31:0] shadow_r, shadow_nxt;
    logic [6:0][31:0] active_r, active_nxt;
    logic [6:0] pend_r, pend_nxt;
    logic [5:0] pwm_r, pwm_nxt;
    logic [6:0] irq_r, irq_nxt;
    logic [6:0] hit_r, hit_nxt;

    logic tick;
    logic [6:0] match;
    logic any_reset;
    logic any_stop;
    logic cycle_start;

    // ------------------------------------------------------------
    // match decode
    // ------------------------------------------------------------
    function automatic logic is_match(input logic [31:0] cnt, input logic [31:0] val);
        is_match = (cnt == val);
    endfunction

    assign tick = (state_r == mbpwm_pkg::MBPWM_RUN) && (pre_r == prescale_limit_in);

    genvar gi;
    generate
        for (gi = 0; gi < mbpwm_pkg::NUM_MATCH; gi++) begin : g_match
            assign match[gi] = tick && is_match(cnt_r, active_r[gi]);
        end
    endgenerate

    always_comb begin
        any_reset = 1'b0;
        any_stop = 1'b0;
        for (int i = 0; i < mbpwm_pkg::NUM_MATCH; i++) begin
            any_reset = any_reset | (match[i] & match_action_in[i].reset);
            any_stop = any_stop | (match[i] & match_action_in[i].stop);
        end
        // in pwm mode match zero always restarts the cycle
        if (pwm_mode_in && match[0]) begin
            any_reset = 1'b1;
        end
        cycle_start = any_reset || (tick && cnt_r == mbpwm_pkg::CNT_RST && !pwm_mode_in);
    end

    // ------------------------------------------------------------
    // counter and prescaler
    // ------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        pre_nxt = pre_r;
        state_nxt = state_r;
        case (state_r)
            mbpwm_pkg::MBPWM_HALT: begin
                if (count_enable_in) begin
                    state_nxt = mbpwm_pkg::MBPWM_RUN;
                end
            end
            mbpwm_pkg::MBPWM_RUN: begin
                if (!count_enable_in) begin
                    state_nxt = mbpwm_pkg::MBPWM_HALT;
                end else if (tick) begin
                    pre_nxt = mbpwm_pkg::PRE_RST;
                    cnt_nxt = any_reset ? mbpwm_pkg::CNT_RST : cnt_r + 32'h0000_0001;
                    if (any_stop) begin
                        state_nxt = mbpwm_pkg::MBPWM_STOPPED;
                    end
                end else begin
                    pre_nxt = pre_r + 32'h0000_0001;
                end
            end
            mbpwm_pkg::MBPWM_STOPPED: begin
                // restarts only after software drops and raises the enable
                if (!count_enable_in) begin
                    state_nxt = mbpwm_pkg::MBPWM_HALT;
                end
            end
            default: state_nxt = mbpwm_pkg::MBPWM_HALT;
        endcase
        if (counter_reset_in) begin
            cnt_nxt = mbpwm_pkg::CNT_RST;
            pre_nxt = mbpwm_pkg::PRE_RST;
        end
    end

    // ------------------------------------------------------------
    // match shadow and release
    // ------------------------------------------------------------
    always_comb begin
        shadow_nxt = shadow_r;
        active_nxt = active_r;
        pend_nxt = pend_r;
        for (int i = 0; i < mbpwm_pkg::NUM_MATCH; i++) begin
            if (match_write_in[i]) begin
                shadow_nxt[i] = match_value_in[i];
            end
            if (match_release_in[i]) begin
                pend_nxt[i] = 1'b1;
            end
            // outside pwm mode or while halted the values apply at once
            if ((pend_r[i] || match_release_in[i]) &&
                (cycle_start || !pwm_mode_in || state_r != mbpwm_pkg::MBPWM_RUN)) begin
                active_nxt[i] = match_write_in[i] ? match_value_in[i] : shadow_r[i];
                pend_nxt[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // pwm outputs and match status
    // ------------------------------------------------------------
    always_comb begin
        pwm_nxt = pwm_r;
        hit_nxt = match;
        irq_nxt = irq_r;
        for (int i = 0; i < mbpwm_pkg::NUM_MATCH; i++) begin
            // sticky, set wins; cleared only by counter reset request
            irq_nxt[i] = (irq_r[i] & ~counter_reset_in) | (match[i] & match_action_in[i].irq);
        end
        for (int k = 1; k <= mbpwm_pkg::NUM_OUT; k++) begin
            if (!pwm_mode_in || !out_cfg_in[k-1].enable) begin
                pwm_nxt[k-1] = 1'b0;
            end else if (out_cfg_in[k-1].double_edge && k >= 2) begin
                // rise on match k-1, fall on match k; any order
                if (match[k]) begin
                    pwm_nxt[k-1] = 1'b0;
                end else if (match[k-1]) begin
                    pwm_nxt[k-1] = 1'b1;
                end
            end else begin
                // a fall at the same count as the rise keeps it constant low
                if (match[k]) begin
                    pwm_nxt[k-1] = 1'b0;
                end else if (match[0]) begin
                    pwm_nxt[k-1] = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= mbpwm_pkg::CNT_RST;
            pre_r <= mbpwm_pkg::PRE_RST;
            state_r <= mbpwm_pkg::MBPWM_HALT;
            shadow_r <= '0;
            active_r <= '0;
            pend_r <= '0;
            pwm_r <= '0;
            irq_r <= '0;
            hit_r <= '0;
        end else if (clk_en_in) begin
            cnt_r <= cnt_nxt;
            pre_r <= pre_nxt;
            state_r <= state_nxt;
            shadow_r <= shadow_nxt;
            active_r <= active_nxt;
            pend_r <= pend_nxt;
            pwm_r <= pwm_nxt;
            irq_r <= irq_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign count_out = cnt_r;
    assign prescale_count_out = pre_r;
    assign running_out = (state_r == mbpwm_pkg::MBPWM_RUN);
    assign match_irq_out = irq_r;
    assign match_hit_out = hit_r;
    assign pwm_out = pwm_r;

endmodule // mbpwm_unit

// *** sim/mbpwm_chk.sv ***
// checker: port level assertions for the match based pwm unit
module mbpwm_chk (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic count_enable_in,
    input wire logic counter_reset_in,
    input wire logic pwm_mode_in,
    input wire logic [31:0] prescale_limit_in,
    input wire logic [31:0] count_out,
    input wire logic [31:0] prescale_count_out,
    input wire logic running_out,
    input wire logic [6:0] match_hit_out,
    input wire logic [5:0] pwm_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic adv;
    logic tick;
    // a dropped run request leaves the prescaler where it is, so it is no step
    assign adv = running_out && clk_en_in && count_enable_in && !counter_reset_in;
    assign tick = prescale_count_out == prescale_limit_in;
    pre_step_a: assert property (adv && !tick |=> prescale_count_out ==
        $past(prescale_count_out) + 32'h1) else $error("prescaler missed a step");
    pre_wrap_a: assert property (adv && tick |=> prescale_count_out == 32'h0)
        else $error("prescaler did not wrap");
    cnt_hold_a: assert property (adv && !tick |=> $stable(count_out))
        else $error("counter moved between ticks");
    halt_hold_a: assert property (!running_out && !counter_reset_in |=> $stable(count_out))
        else $error("counter moved while halted");
    clr_zero_a: assert property (counter_reset_in && clk_en_in |=>
        count_out == 32'h0 && prescale_count_out == 32'h0) else $error("clear failed");
    cyc_restart_a: assert property (match_hit_out[0] && $past(pwm_mode_in) |->
        count_out == 32'h0) else $error("cycle did not restart");
    plain_low_a: assert property (!pwm_mode_in && clk_en_in |=> pwm_out == 6'h00)
        else $error("pwm output active in timer mode");
    halt_req_a: assert property (!count_enable_in && clk_en_in |=> !running_out)
        else $error("still running after halt request");
endmodule // mbpwm_chk

bind mbpwm_unit mbpwm_chk u_chk (.core_clk_in, .rst_in, .clk_en_in, .count_enable_in,
    .counter_reset_in, .pwm_mode_in, .prescale_limit_in, .count_out,
    .prescale_count_out, .running_out, .match_hit_out, .pwm_out);

// *** sim/mbpwm_unit_tb.sv ***
// testbench: drives the pwm unit through its ports and checks its outputs
module mbpwm_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
    logic count_enable_in = 1'b0, counter_reset_in = 1'b0, pwm_mode_in = 1'b0;
    logic [31:0] prescale_limit_in = 32'h1, m1 = 32'h2, held = '0;
    logic [6:0][31:0] match_value_in = '0;
    logic [6:0] match_write_in = '0, match_release_in = '0;
    mbpwm_pkg::mbpwm_act_type [6:0] match_action_in = '0;
    mbpwm_pkg::mbpwm_outcfg_type [5:0] out_cfg_in = '0;
    logic [31:0] count_out, prescale_count_out;
    logic running_out;
    logic [6:0] match_irq_out, match_hit_out;
    logic [5:0] pwm_out;
    int mismatches = 0, total_checks = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    mbpwm_unit u_dut (.core_clk_in, .rst_in, .clk_en_in, .count_enable_in, .counter_reset_in,
        .pwm_mode_in, .prescale_limit_in, .match_value_in, .match_write_in, .match_release_in,
        .match_action_in, .out_cfg_in, .count_out, .prescale_count_out, .running_out,
        .match_irq_out, .match_hit_out, .pwm_out);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic put(input int k, input logic [31:0] v, input logic rel);
        @(negedge core_clk_in);
        match_value_in[k] = v;
        match_write_in[k] = 1'b1;
        match_release_in[k] = rel;
        @(negedge core_clk_in);
        match_write_in = '0;
        match_release_in = '0;
    endtask
    task automatic wait_hit(input int b);
        for (int n = 0; n < 200 && match_hit_out[b] !== 1'b1; n++) @(negedge core_clk_in);
    endtask
    // out1 single, out3 positive, out5 negative, out6 single
    function automatic logic [5:0] exp_pwm(input logic [31:0] c);
        exp_pwm = {c <= 32'h3, c > 32'h2 || c <= 32'h1, 1'b0,
            c > 32'h2 && c <= 32'h4, 1'b0, c <= m1};
    endfunction
    task automatic watch(input int n);
        repeat (n) begin
            check(32'(pwm_out), 32'(exp_pwm(count_out)));
            @(negedge core_clk_in);
        end
    endtask
    initial begin
        #100us;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (6) @(negedge core_clk_in);
        rst_in = 1'b0;
        check(32'({running_out, pwm_out, match_irq_out}), 32'h0);
        check(count_out | prescale_count_out, 32'h0);
        out_cfg_in = {2'b10, 2'b11, 2'b00, 2'b11, 2'b00, 2'b10};
        for (int k = 0; k < 7; k++) begin
            put(k, 32'(k == 0 ? 5 : 2 + 2 * (k % 2) - (k == 5) * 3), 1'b1);
        end
        put(6, 32'h3, 1'b1);
        put(1, 32'h2, 1'b1);
        pwm_mode_in = 1'b1;
        count_enable_in = 1'b1;
        wait_hit(0);
        watch(24);
        put(1, 32'h4, 1'b0);
        wait_hit(0);
        watch(12);
        wait_hit(0);
        put(1, 32'h4, 1'b1);
        watch(8);
        m1 = 32'h4;
        wait_hit(0);
        watch(24);
        match_action_in[3] = 3'b101;
        wait_hit(3);
        check(32'({running_out, match_irq_out[3]}), 32'h1);
        check(32'(match_hit_out), 32'h0000_000a);
        check(count_out, 32'h5);
        match_action_in = '0;
        count_enable_in = 1'b0;
        counter_reset_in = 1'b1;
        pwm_mode_in = 1'b0;
        @(negedge core_clk_in);
        check(32'(match_irq_out) | count_out, 32'h0);
        counter_reset_in = 1'b0;
        count_enable_in = 1'b1;
        repeat (40) @(negedge core_clk_in);
        clk_en_in = 1'b0;
        held = count_out;
        repeat (4) @(negedge core_clk_in);
        check(count_out, held);
        clk_en_in = 1'b1;
        check(32'(pwm_out), 32'h0);
        check(32'(count_out > 32'h5), 32'h1);
        finish_test();
    end
endmodule // mbpwm_unit_tb
